// file: bench/dmr_host_model.sv
`timescale 1ns/1ps
module dmr_host_model (
    input wire logic clk, // System clock
    output logic reg_wr_en, // Write strobe
    output logic reg_rd_en, // Read strobe
    output logic [6:0] reg_addr, // Register address
    output logic [7:0] reg_wdata, // Write data
    input wire logic [7:0] reg_rdata, // Read data
    input wire logic reg_rvalid // Read data valid
);
    // Idle bus at time zero
    initial
    begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 7'h00;
        reg_wdata = 8'h00;
    end

    // One write; released lines show the inverse of the last value
    // Ones clear flags
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk);
        #1;
        reg_wr_en = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask

    // One read; the answer stands for the single cycle after the strobe
    task automatic rd(input logic [6:0] a, output logic [7:0] d, output bit ok);
        @(posedge clk);
        #1;
        reg_rd_en = 1'b1;
        reg_addr = a;
        @(posedge clk);
        #1;
        reg_rd_en = 1'b0;
        reg_addr = ~a;
        ok = (reg_rvalid === 1'b1);
        d = reg_rdata;
    endtask
endmodule // dmr_host_model

// file: bench/tb.sv
`timescale 1ns/1ps
module tb
    import dmr_pkg::*;
;
    typedef struct packed {
        logic [6:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } dmr_row_t;

    logic clk = 1'b0;
    logic rst_n, busy, auto_mode, ext_addr_hit, if_crc_evt, map_crc_evt, rom_crc_evt;
    logic reg_wr_en, reg_rd_en, reg_rvalid;
    logic [6:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, open_det_raw, ov_det_raw, uv_det_raw;
    logic [7:0] diag_en, open_detect_run, pga_cm_high, range_check_run;
    logic [1:0] range_10v_force;
    dmr_route_t route_ch1, route_ch2;
    int mismatches = 0;
    int n_compared = 0;
    dmr_row_t rows [6] = '{'{7'h23, 8'hA5, 8'hA5}, '{7'h25, 8'h3C, 8'h3C}, '{7'h28, 8'hFF, 8'h3F},
                           '{7'h22, 8'hFF, 8'h00}, '{7'h24, 8'hFF, 8'h00}, '{7'h21, 8'h18, 8'h18}};

    // 100 MHz clock
    always #5 clk = ~clk;

    dmr_host_model host (.clk(clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    dmr_top dut (.clk(clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .ext_addr_hit(ext_addr_hit), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .busy(busy), .auto_mode(auto_mode), .if_crc_evt(if_crc_evt),
        .map_crc_evt(map_crc_evt), .rom_crc_evt(rom_crc_evt), .open_det_raw(open_det_raw),
        .ov_det_raw(ov_det_raw), .uv_det_raw(uv_det_raw), .diag_en(diag_en),
        .open_detect_run(open_detect_run), .pga_cm_high(pga_cm_high), .range_check_run(range_check_run),
        .route_ch1(route_ch1), .route_ch2(route_ch2), .range_10v_force(range_10v_force));

    // ----------------------------------------------------------------
    // Check and report tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask

    // Read a register through the host and compare
    task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] d;
        bit ok;
        host.rd(a, d, ok);
        if (!ok)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: no read answer at %h", $time, a);
        end
        chk(d, exp, $sformatf("read %h", a));
    endtask

    // One-cycle pulse on all three checksum events
    task automatic crc_pulse();
        @(posedge clk);
        #1;
        {if_crc_evt, map_crc_evt, rom_crc_evt} = 3'b111;
        @(posedge clk);
        #1;
        {if_crc_evt, map_crc_evt, rom_crc_evt} = 3'b000;
    endtask

    // Busy held high for n edges
    task automatic busy_for(input int n);
        @(posedge clk);
        #1;
        busy = 1'b1;
        repeat (n) @(posedge clk);
        #1;
        busy = 1'b0;
    endtask

    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Hang guard
    initial
    begin
        #500_000;
        mismatches++;
        $display("CHECK FAILED at %0t: run did not finish", $time);
        end_sim();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        {rst_n, busy, auto_mode, ext_addr_hit, if_crc_evt, map_crc_evt, rom_crc_evt} = 7'h00;
        {open_det_raw, ov_det_raw, uv_det_raw} = 24'h00_0000;
        repeat (6) @(posedge clk);
        #1;
        rst_n = 1'b1;
        rchk(7'h21, 8'h01);
        for (int a = 8'h22; a <= 8'h28; a++)
            rchk(7'(a), 8'h00);
        chk(8'(route_ch1), 8'(ROUTE_PIN), "route after reset");
        $display("test reset done");

        foreach (rows[i])
        begin
            host.wr(rows[i].a, rows[i].d);
            rchk(rows[i].a, rows[i].e);
        end
        chk(diag_en, 8'h18, "enable copy");
        $display("test table done");

        rchk(7'h40, 8'h00);
        host.wr(7'h41, 8'h55);
        rchk(7'h22, 8'h18);
        host.wr(7'h22, 8'h08);
        rchk(7'h22, 8'h10);
        host.wr(7'h22, 8'hFF);
        ext_addr_hit = 1'b1;
        host.wr(7'h41, 8'h00);
        ext_addr_hit = 1'b0;
        host.wr(7'h21, 8'h00);
        rchk(7'h40, 8'h00);
        host.wr(7'h41, 8'h00);
        rchk(7'h22, 8'h00);
        $display("test bad address done");

        host.wr(7'h21, 8'h06);
        crc_pulse();
        rchk(7'h22, 8'h06);
        host.wr(7'h21, 8'h01);
        crc_pulse();
        rchk(7'h22, 8'h07);
        host.wr(7'h22, 8'hFF);
        $display("test checksum done");

        host.wr(7'h21, 8'h20);
        busy_for(400);
        rchk(7'h22, 8'h00);
        busy_for(401);
        rchk(7'h22, 8'h20);
        host.wr(7'h22, 8'hFF);
        host.wr(7'h21, 8'h00);
        busy_for(405);
        rchk(7'h22, 8'h00);
        $display("test hang done");

        auto_mode = 1'b1;
        host.wr(7'h23, 8'h01);
        host.wr(7'h25, 8'h81);
        open_det_raw = 8'h81;
        ov_det_raw = 8'h81;
        uv_det_raw = 8'h82;
        repeat (5) @(posedge clk);
        #1;
        {open_det_raw, ov_det_raw, uv_det_raw} = 24'h00_0000;
        rchk(7'h24, 8'h01);
        rchk(7'h26, 8'h81);
        rchk(7'h27, 8'h80);
        chk(open_detect_run, 8'h01, "open run");
        chk(range_check_run, 8'h81, "range run");
        host.wr(7'h26, 8'h01);
        rchk(7'h26, 8'h80);
        host.wr(7'h24, 8'hFF);
        rchk(7'h24, 8'h00);
        auto_mode = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk(pga_cm_high, 8'h01, "common mode");
        chk(open_detect_run, 8'h00, "open run manual");
        $display("test detection done");

        for (int c = 0; c < 8; c++)
        begin
            host.wr(7'h28, {2'b11, 3'(7 - c), 3'(c)});
            repeat (2) @(posedge clk);
            #1;
            chk(8'(route_ch1), 8'(c), "ch1 route");
            chk(8'(route_ch2), (c == 3) ? 8'(ROUTE_AREG) : 8'(7 - c), "ch2 route");
            chk({6'h00, 1'((7 - c) != 0), 1'(c != 0)}, 8'(range_10v_force), "range force");
        end
        $display("test selector done");

        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        rst_n = 1'b1;
        rchk(7'h21, 8'h01);
        rchk(7'h26, 8'h00);
        rchk(7'h28, 8'h00);
        chk(pga_cm_high, 8'h00, "common mode after reset");
        chk(8'(route_ch2), 8'(ROUTE_PIN), "route 2 after reset");
        $display("test mid-run reset done");
        end_sim();
    end
endmodule // tb

// file: hdl/dmr_consts.svh
// Overview of operation
// - Set hang flag, fault bit 5, when busy stays high longer than 4 us.
// - Set bad-read-address flag, fault bit 4, on a read of an unmapped address.
// - Set bad-write-address flag, fault bit 3, on a write to an unmapped address.
// - Checksum faults: interface bit 2, register map bit 1, fuse/ROM bit 0.
// - Automatic mode: open-check enable bit n runs open detection on channel n+1.
// - Manual mode: open-check enable bit drives that channel's amplifier common mode high.
// - Open input detected sets per-channel open flag; each flag cleared by writing one.
// - Range-check enable bit n enables over/undervoltage checks on channel n+1; reset off.
// - Enabled overvoltage detection sets per-channel flag; cleared by writing one.
// - Enabled undervoltage detection sets per-channel flag; cleared by writing one.
// - Source select: channel 2 in bits 5:3, channel 1 in 2:0; bits 7:6 read-only.
// - Any diagnostic source selected forces that channel to the +/-10 V range.
// - Code 000 own input pin, 001 die temperature, 010 2.5 V reference.
// - Code 011 analog regulator x4; code 100 digital (ch1) or analog (ch2) regulator.
// - Code 101 interface supply, 110 analog ground, 111 analog supply.
// - Hang flag raised only while hang check enable, bit 5, is set.
// - Bad read/write address flags raised only while enable bits 4 / 3 set.
// - Checksum flags gated by enable bits 2,1,0; ROM check enabled after reset.
`ifndef DMR_CONSTS_SVH
`define DMR_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define DMR_ADDR_DIAG_EN 7'h21
`define DMR_ADDR_FAULT 7'h22
`define DMR_ADDR_OPEN_EN 7'h23
`define DMR_ADDR_OPEN_FLAGS 7'h24
`define DMR_ADDR_RANGE_EN 7'h25
`define DMR_ADDR_OV_FLAGS 7'h26
`define DMR_ADDR_UV_FLAGS 7'h27
`define DMR_ADDR_SRC_SEL 7'h28

// ----------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------
`define DMR_RST_DIAG_EN 8'h01
`define DMR_RST_ZERO 8'h00
`define DMR_BIT_HANG 5
`define DMR_BIT_RD_ADDR 4
`define DMR_BIT_WR_ADDR 3
`define DMR_BIT_IF_CRC 2
`define DMR_BIT_MAP_CRC 1
`define DMR_BIT_ROM_CRC 0
`define DMR_FAULT_MASK 8'h3F
`define DMR_SRC_MASK 8'h3F
`define DMR_SRC_CH2_LSB 3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DMR_CLK_PERIOD_NS 10
`define DMR_HANG_TIME_NS 4000
`define DMR_HANG_CYCLES ((`DMR_HANG_TIME_NS + `DMR_CLK_PERIOD_NS - 1) / `DMR_CLK_PERIOD_NS)
`define DMR_HANG_CNT_W 16

`endif

// file: hdl/dmr_hang_mon.sv
`timescale 1ns/1ps
`include "dmr_consts.svh"
module dmr_hang_mon
    import dmr_pkg::*;
#(
    parameter logic [`DMR_HANG_CNT_W-1:0] HANG_CYCLES = `DMR_HANG_CNT_W'(`DMR_HANG_CYCLES)
)(
    input wire logic clk,  // System clock
    input wire logic rst_n,  // Synchronous reset, active low
    input wire logic busy,  // Conversion busy level
    output logic hang_pulse  // One cycle when busy exceeds limit
);
    typedef struct packed {
        logic [`DMR_HANG_CNT_W-1:0] cnt;
        logic pulse;
    } dmr_hang_state_t;

    dmr_hang_state_t r_q;
    dmr_hang_state_t r_d;

    // Count busy-high cycles; fire once when the limit is passed
    always_comb
    begin
        r_d = r_q;
        r_d.pulse = 1'b0;
        if (!busy)
        begin
            r_d.cnt = '0;
        end
        else if (r_q.cnt <= HANG_CYCLES)
        begin
            r_d.cnt = r_q.cnt + 1'b1;
            r_d.pulse = (r_q.cnt == HANG_CYCLES);
        end
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            r_q <= '0;
        else
            r_q <= r_d;
    end

    assign hang_pulse = r_q.pulse;
endmodule // dmr_hang_mon

// file: hdl/dmr_pkg.sv
package dmr_pkg;
    // Diagnostic source routes of one channel
    typedef enum logic [2:0] {
        ROUTE_PIN,
        ROUTE_TEMP,
        ROUTE_REF,
        ROUTE_AREG,
        ROUTE_DREG,
        ROUTE_IOSUP,
        ROUTE_ANALOG_GROUND,
        ROUTE_ASUP
    } dmr_route_t;

    // Register selected by an access
    typedef enum logic [3:0] {
        SEL_DIAG_EN,
        SEL_FAULT,
        SEL_OPEN_EN,
        SEL_OPEN_FLAGS,
        SEL_RANGE_EN,
        SEL_OV_FLAGS,
        SEL_UV_FLAGS,
        SEL_SRC,
        SEL_NONE
    } dmr_sel_t;
endpackage

// file: hdl/dmr_src_decode.sv
`timescale 1ns/1ps
module dmr_src_decode
    import dmr_pkg::*;
#(
    parameter bit CODE4_DIGITAL = 1'b1
)(
    input wire logic [2:0] code,  // Selector field
    output dmr_route_t route,  // Routed source
    output logic force_10v  // Channel forced to +/-10 V range
);
    // Map selector code to a source
    always_comb
    begin
        case (code)
            3'h0: route = ROUTE_PIN;
            3'h1: route = ROUTE_TEMP;
            3'h2: route = ROUTE_REF;
            3'h3: route = ROUTE_AREG;
            3'h4: route = CODE4_DIGITAL ? ROUTE_DREG : ROUTE_AREG;
            3'h5: route = ROUTE_IOSUP;
            3'h6: route = ROUTE_ANALOG_GROUND;
            default: route = ROUTE_ASUP;
        endcase
        force_10v = (code != 3'h0);
    end
endmodule // dmr_src_decode

// file: hdl/dmr_top.sv
`timescale 1ns/1ps
`include "dmr_consts.svh"
module dmr_top
    import dmr_pkg::*;
(
    input wire logic clk,  // System clock, 100 MHz
    input wire logic rst_n,  // Synchronous reset, active low
    input wire logic reg_wr_en,  // Register write strobe
    input wire logic reg_rd_en,  // Register read strobe
    input wire logic [6:0] reg_addr,  // Register address
    input wire logic [7:0] reg_wdata,  // Write data
    input wire logic ext_addr_hit,  // Address claimed by another bank
    output logic [7:0] reg_rdata,  // Read data
    output logic reg_rvalid,  // Read data valid pulse
    input wire logic busy,  // Conversion busy level
    input wire logic auto_mode,  // 1 automatic, 0 manual open detect
    input wire logic if_crc_evt,  // Interface checksum fault pulse
    input wire logic map_crc_evt,  // Register map checksum fault pulse
    input wire logic rom_crc_evt,  // Fuse/ROM checksum fault pulse
    input wire logic [7:0] open_det_raw,  // Open input comparators, async
    input wire logic [7:0] ov_det_raw,  // Overvoltage comparators, async
    input wire logic [7:0] uv_det_raw,  // Undervoltage comparators, async
    output logic [7:0] diag_en,  // Diagnostic enable register
    output logic [7:0] open_detect_run,  // Run open detection per channel
    output logic [7:0] pga_cm_high,  // Amplifier common mode high
    output logic [7:0] range_check_run,  // Over/under checks enabled
    output dmr_route_t route_ch1,  // Channel 1 source
    output dmr_route_t route_ch2,  // Channel 2 source
    output logic [1:0] range_10v_force  // Channels 2..1 forced to 10 V
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] diag_en;
        logic [7:0] fault;
        logic [7:0] open_en;
        logic [7:0] open_flag;
        logic [7:0] range_en;
        logic [7:0] ov_flag;
        logic [7:0] uv_flag;
        logic [5:0] src_sel;
        logic [7:0] rdata;
        logic rvalid;
        logic [7:0] open_s1;
        logic [7:0] open_s2;
        logic [7:0] ov_s1;
        logic [7:0] ov_s2;
        logic [7:0] uv_s1;
        logic [7:0] uv_s2;
        logic [7:0] open_run;
        logic [7:0] cm_high;
        logic [7:0] range_run;
        dmr_route_t route1;
        dmr_route_t route2;
        logic [1:0] force_10v;
    } dmr_top_state_t;

    dmr_top_state_t r_q;
    dmr_top_state_t r_d;
    logic hang_pulse;
    dmr_route_t dec_route1;
    dmr_route_t dec_route2;
    logic dec_f1;
    logic dec_f2;
    dmr_sel_t sel;
    logic [7:0] wr_clr;
    logic [7:0] rd_val;

    // Address decoding shared by read and write paths
    function automatic dmr_sel_t dmr_decode(input logic [6:0] a);
        if (a == `DMR_ADDR_DIAG_EN)
            return SEL_DIAG_EN;
        else if (a == `DMR_ADDR_FAULT)
            return SEL_FAULT;
        else if (a == `DMR_ADDR_OPEN_EN)
            return SEL_OPEN_EN;
        else if (a == `DMR_ADDR_OPEN_FLAGS)
            return SEL_OPEN_FLAGS;
        else if (a == `DMR_ADDR_RANGE_EN)
            return SEL_RANGE_EN;
        else if (a == `DMR_ADDR_OV_FLAGS)
            return SEL_OV_FLAGS;
        else if (a == `DMR_ADDR_UV_FLAGS)
            return SEL_UV_FLAGS;
        else if (a == `DMR_ADDR_SRC_SEL)
            return SEL_SRC;
        else
            return SEL_NONE;
    endfunction

    // Sticky flag update: set wins over a write-one clear
    function automatic logic [7:0] dmr_sticky(input logic [7:0] flag, input logic [7:0] clr,
                                              input logic [7:0] set);
        return (flag & ~clr) | set;
    endfunction

    // ----------------------------------------------------------------
    // Submodules
    // ----------------------------------------------------------------
    dmr_hang_mon u_hang (
        .clk(clk),
        .rst_n(rst_n),
        .busy(busy),
        .hang_pulse(hang_pulse)
    );

    dmr_src_decode #(.CODE4_DIGITAL(1'b1)) u_dec1 (
        .code(r_q.src_sel[2:0]),
        .route(dec_route1),
        .force_10v(dec_f1)
    );

    dmr_src_decode #(.CODE4_DIGITAL(1'b0)) u_dec2 (
        .code(r_q.src_sel[5:3]),
        .route(dec_route2),
        .force_10v(dec_f2)
    );

    // Decode and read mux
    always_comb
    begin
        sel = dmr_decode(reg_addr);
        wr_clr = reg_wr_en ? reg_wdata : 8'h00;
        case (sel)
            SEL_DIAG_EN: rd_val = r_q.diag_en;
            SEL_FAULT: rd_val = r_q.fault & `DMR_FAULT_MASK;
            SEL_OPEN_EN: rd_val = r_q.open_en;
            SEL_OPEN_FLAGS: rd_val = r_q.open_flag;
            SEL_RANGE_EN: rd_val = r_q.range_en;
            SEL_OV_FLAGS: rd_val = r_q.ov_flag;
            SEL_UV_FLAGS: rd_val = r_q.uv_flag;
            SEL_SRC: rd_val = {2'b00, r_q.src_sel};
            default: rd_val = 8'h00;
        endcase
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        r_d = r_q;
        // Two-stage synchronisers for comparator inputs
        r_d.open_s1 = open_det_raw;
        r_d.open_s2 = r_q.open_s1;
        r_d.ov_s1 = ov_det_raw;
        r_d.ov_s2 = r_q.ov_s1;
        r_d.uv_s1 = uv_det_raw;
        r_d.uv_s2 = r_q.uv_s1;

        // Plain read/write registers
        if (reg_wr_en && sel == SEL_DIAG_EN)
            r_d.diag_en = reg_wdata;
        if (reg_wr_en && sel == SEL_OPEN_EN)
            r_d.open_en = reg_wdata;
        if (reg_wr_en && sel == SEL_RANGE_EN)
            r_d.range_en = reg_wdata;
        if (reg_wr_en && sel == SEL_SRC)
            r_d.src_sel = reg_wdata[5:0];

        r_d.fault = dmr_sticky(r_q.fault, (sel == SEL_FAULT) ? wr_clr : 8'h00, 8'h00);
        if (hang_pulse && r_q.diag_en[`DMR_BIT_HANG])
            r_d.fault[`DMR_BIT_HANG] = 1'b1;
        if (reg_rd_en && sel == SEL_NONE && !ext_addr_hit && r_q.diag_en[`DMR_BIT_RD_ADDR])
            r_d.fault[`DMR_BIT_RD_ADDR] = 1'b1;
        if (reg_wr_en && sel == SEL_NONE && !ext_addr_hit && r_q.diag_en[`DMR_BIT_WR_ADDR])
            r_d.fault[`DMR_BIT_WR_ADDR] = 1'b1;
        if (if_crc_evt && r_q.diag_en[`DMR_BIT_IF_CRC])
            r_d.fault[`DMR_BIT_IF_CRC] = 1'b1;
        if (map_crc_evt && r_q.diag_en[`DMR_BIT_MAP_CRC])
            r_d.fault[`DMR_BIT_MAP_CRC] = 1'b1;
        if (rom_crc_evt && r_q.diag_en[`DMR_BIT_ROM_CRC])
            r_d.fault[`DMR_BIT_ROM_CRC] = 1'b1;
        r_d.fault = r_d.fault & `DMR_FAULT_MASK;

        r_d.open_flag = dmr_sticky(r_q.open_flag, (sel == SEL_OPEN_FLAGS) ? wr_clr : 8'h00,
                                   r_q.open_s2 & r_q.open_run);
        r_d.ov_flag = dmr_sticky(r_q.ov_flag, (sel == SEL_OV_FLAGS) ? wr_clr : 8'h00,
                                 r_q.ov_s2 & r_q.range_en);
        r_d.uv_flag = dmr_sticky(r_q.uv_flag, (sel == SEL_UV_FLAGS) ? wr_clr : 8'h00,
                                 r_q.uv_s2 & r_q.range_en);

        // Read answer one cycle after the strobe
        r_d.rvalid = reg_rd_en;
        r_d.rdata = reg_rd_en ? rd_val : 8'h00;

        r_d.open_run = auto_mode ? r_q.open_en : 8'h00;
        r_d.cm_high = auto_mode ? 8'h00 : r_q.open_en;
        r_d.range_run = r_q.range_en;
        r_d.route1 = dec_route1;
        r_d.route2 = dec_route2;
        r_d.force_10v = {dec_f2, dec_f1};
    end

    // State register with reset values
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            r_q <= '0;
            r_q.diag_en <= `DMR_RST_DIAG_EN;
            r_q.route1 <= ROUTE_PIN;
            r_q.route2 <= ROUTE_PIN;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign reg_rdata = r_q.rdata;
    assign reg_rvalid = r_q.rvalid;
    assign diag_en = r_q.diag_en;
    assign open_detect_run = r_q.open_run;
    assign pga_cm_high = r_q.cm_high;
    assign range_check_run = r_q.range_run;
    assign route_ch1 = r_q.route1;
    assign route_ch2 = r_q.route2;
    assign range_10v_force = r_q.force_10v;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    property p_hang_set;
        hang_pulse && r_q.diag_en[`DMR_BIT_HANG] |=> r_q.fault[`DMR_BIT_HANG];
    endproperty
    a_hang_set: assert property (p_hang_set) else $error("hang flag not set");

    property p_hang_time;
        !busy ##1 busy [*8] |-> !hang_pulse;
    endproperty
    a_hang_time: assert property (p_hang_time) else $error("hang flagged too early");

    property p_hang_gate;
        $rose(r_q.fault[`DMR_BIT_HANG]) |-> $past(r_q.diag_en[`DMR_BIT_HANG]);
    endproperty
    a_hang_gate: assert property (p_hang_gate) else $error("hang flag raised while disabled");

    property p_bad_rd;
        reg_rd_en && !ext_addr_hit && dmr_decode(reg_addr) == SEL_NONE
            && r_q.diag_en[`DMR_BIT_RD_ADDR] |=> r_q.fault[`DMR_BIT_RD_ADDR];
    endproperty
    a_bad_rd: assert property (p_bad_rd) else $error("bad read address not flagged");

    property p_bad_wr_gate;
        $rose(r_q.fault[`DMR_BIT_WR_ADDR]) |-> $past(r_q.diag_en[`DMR_BIT_WR_ADDR]) && $past(reg_wr_en);
    endproperty
    a_bad_wr_gate: assert property (p_bad_wr_gate) else $error("bad write flag without write");

    property p_bad_wr;
        reg_wr_en && !ext_addr_hit && dmr_decode(reg_addr) == SEL_NONE
            && r_q.diag_en[`DMR_BIT_WR_ADDR] |=> r_q.fault[`DMR_BIT_WR_ADDR];
    endproperty
    a_bad_wr: assert property (p_bad_wr) else $error("bad write address not flagged");

    property p_bad_rd_gate;
        $rose(r_q.fault[`DMR_BIT_RD_ADDR]) |-> $past(r_q.diag_en[`DMR_BIT_RD_ADDR]) && $past(reg_rd_en);
    endproperty
    a_bad_rd_gate: assert property (p_bad_rd_gate) else $error("bad read flag without read");

    property p_fault_gate;
        (r_q.fault & ~$past(r_q.fault) & ~$past(r_q.diag_en) & `DMR_FAULT_MASK) == 8'h00;
    endproperty
    a_fault_gate: assert property (p_fault_gate) else $error("fault flag raised while disabled");

    property p_rom_crc;
        rom_crc_evt && r_q.diag_en[`DMR_BIT_ROM_CRC] |=> r_q.fault[`DMR_BIT_ROM_CRC];
    endproperty
    a_rom_crc: assert property (p_rom_crc) else $error("rom checksum fault lost");

    property p_open_set;
        (r_q.open_s2 & r_q.open_run) != 8'h00
            |=> (r_q.open_flag & $past(r_q.open_s2) & $past(r_q.open_run))
                == ($past(r_q.open_s2) & $past(r_q.open_run));
    endproperty
    a_open_set: assert property (p_open_set) else $error("open flag not set");

    property p_ov_set;
        (r_q.ov_s2 & r_q.range_en) != 8'h00
            |=> (r_q.ov_flag & $past(r_q.ov_s2) & $past(r_q.range_en)) == ($past(r_q.ov_s2) & $past(r_q.range_en));
    endproperty
    a_ov_set: assert property (p_ov_set) else $error("overvoltage flag not set");

    property p_ov_sticky;
        !(reg_wr_en && reg_addr == `DMR_ADDR_OV_FLAGS)
            |=> (r_q.ov_flag & $past(r_q.ov_flag)) == $past(r_q.ov_flag);
    endproperty
    a_ov_sticky: assert property (p_ov_sticky) else $error("overvoltage flag dropped");

    property p_uv_gate;
        (r_q.uv_flag & ~$past(r_q.uv_flag) & ~$past(r_q.range_en)) == 8'h00;
    endproperty
    a_uv_gate: assert property (p_uv_gate) else $error("undervoltage flag on disabled channel");

    property p_manual_cm;
        !auto_mode |=> pga_cm_high == $past(r_q.open_en) && open_detect_run == 8'h00;
    endproperty
    a_manual_cm: assert property (p_manual_cm) else $error("manual common mode wrong");

    property p_auto_run;
        auto_mode |=> open_detect_run == $past(r_q.open_en) && pga_cm_high == 8'h00;
    endproperty
    a_auto_run: assert property (p_auto_run) else $error("automatic open detection wrong");

    property p_src_rsvd;
        reg_rd_en && reg_addr == `DMR_ADDR_SRC_SEL |=> reg_rvalid && reg_rdata[7:6] == 2'b00;
    endproperty
    a_src_rsvd: assert property (p_src_rsvd) else $error("reserved bits not zero");

    property p_ch1_dreg;
        r_q.src_sel[2:0] == 3'h4 |=> route_ch1 == ROUTE_DREG && range_10v_force[0];
    endproperty
    a_ch1_dreg: assert property (p_ch1_dreg) else $error("channel 1 code 100 misrouted");

    property p_ch2_pin;
        r_q.src_sel[5:3] == 3'h0 |=> route_ch2 == ROUTE_PIN && !range_10v_force[1];
    endproperty
    a_ch2_pin: assert property (p_ch2_pin) else $error("channel 2 pin route wrong");

    c_hang: cover property (hang_pulse && r_q.diag_en[`DMR_BIT_HANG]);
    c_clear_race: cover property (reg_wr_en && sel == SEL_OPEN_FLAGS && (r_q.open_s2 & r_q.open_run) != 8'h00);
    c_bad_rd: cover property (reg_rd_en && sel == SEL_NONE && !ext_addr_hit);
    c_diag_src: cover property (range_10v_force == 2'b11);
endmodule // dmr_top
